// >>> src/spi_eeprom_pins.sv
/*
 * pin-level slave side of a small serial eeprom: frame control, hold,
 * write protect, status bits and the internal program timer.
 * assumes the pins are asynchronous to clock and slow against it;
 * the memory array itself lives outside, behind the memWr and memRd ports.
 */
// Contract
// R01 - cs high: deselected, output tri-stated
// R02 - standby when idle; deselect never aborts programming
// R03 - cs low makes device active
// R04 - host sends opcode first each frame
// R05 - sample data in on rising serial clock
// R06 - opcode, then address, then data, one frame
// R07 - change data out on falling serial clock only
// R08 - write protect low clears write enable latch
// R09 - protected: no programming, other commands work
// R10 - hold pauses transfer, stays selected
// R11 - hold: output tri-stated, clock and data ignored
// R12 - host keeps cs low during hold
// R13 - programming cycle ends within 4.0 ms
// R14 - cs rise resets bit counter and decoder
// R15 - opcode is one byte, msb first
// R16 - undefined opcode: ignore rest of frame
// R17 - only write-enable command sets latch
// R18 - write-in-progress one only while programming
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_pins
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    input  wire logic       csPin_n,
    input  wire logic       sckPin,
    input  wire logic       siPin,
    input  wire logic       wpPin_n,
    input  wire logic       holdPin_n,
    output logic            soOut,
    output logic            soOe,
    output logic            memWrValid,
    output logic [8:0]      memWrAddr,
    output logic [7:0]      memWrData,
    output logic            memRdReq,
    output logic [8:0]      memRdAddr,
    input  wire logic [7:0] memRdData,
    output logic [1:0]      blockProt,
    output logic            writeInProgress,
    output logic            writeEnableLatch
);
    // =========================================================
    // synchronisers
    logic [4:0] syncA_r;
    logic [4:0] syncB_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // idle levels, so no false edge follows reset
            syncA_r <= 5'h13;
            syncB_r <= 5'h13;
        end else if (clkEn) begin
            syncA_r <= {csPin_n, sckPin, siPin, wpPin_n, holdPin_n};
            syncB_r <= syncA_r;
        end
    end
    wire csN   = syncB_r[4];
    wire sck   = syncB_r[3];
    wire si    = syncB_r[2];
    wire wpN   = syncB_r[1];
    wire holdN = syncB_r[0];

    logic sckPrev_r;
    logic csPrev_r;
    wire  active  = !csN && holdN;                  // R03 R10 R11
    wire  sckRise = active && sck && !sckPrev_r;    // R05 R11
    wire  sckFall = active && !sck && sckPrev_r;    // R07 R11
    wire  csRise  = csN && !csPrev_r;

    // =========================================================
    // frame decoder
    phase_e     phase_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [7:0] opc_r;
    logic [8:0] addr_r;
    logic [7:0] txByte_r;
    logic       so_r;
    logic       oe_r;
    logic       wel_r;
    logic [1:0] bp_r;
    logic       busy_r;
    logic [$clog2(PROG_CYCLES+1)-1:0] progCnt_r;
    logic       discard_r;
    logic       memRdAck_r;
    logic       soLive_r;

    wire [7:0] rxByte   = {shift_r[6:0], si};           // R15
    wire       byteDone = sckRise && (bitCnt_r == BIT_LAST);
    wire [7:0] opcM     = rxByte & OPC_MASK;
    wire [7:0] opcBase  = {opcM[7:4], 1'b0, opcM[2:0]};
    wire       opcValid = (opcM[7:4] == 4'h0) &&
                          (opcBase == OPC_SET_WEL || opcBase == OPC_CLR_WEL ||
                           opcBase == OPC_STAT_RD || opcBase == OPC_STAT_ST ||
                           opcBase == OPC_MEM_RD  || opcBase == OPC_MEM_WR);
    wire       isRead   = (opc_r == OPC_STAT_RD) || (opc_r == OPC_MEM_RD);
    wire       isWrite  = (opc_r == OPC_MEM_WR) || (opc_r == OPC_STAT_ST);
    wire       wrAllow  = wel_r && wpN && !busy_r;      // R09
    wire [7:0] statByte = {STAT_TOP_ONES, bp_r, wel_r, busy_r};

    // page bytes queue up until cs rises, then start one program cycle
    logic    fifoInValid;
    logic    fifoInReady;
    wr_req_s fifoIn;
    logic    fifoOutValid;
    wr_req_s fifoOut;
    wire     drain = fifoOutValid && (busy_r || discard_r);
    assign fifoInValid = byteDone && phase_r == PH_DATA && isWrite   // R09
                         && wrAllow && fifoInReady;
    assign fifoIn      = '{isStatus: opc_r == OPC_STAT_ST, addr: addr_r, data: rxByte};

    wr_fifo #(.WIDTH($bits(wr_req_s)), .DEPTH(FIFO_DEPTH)) uFifo (
        .clock    (clock),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (drain),
        .outData  (fifoOut)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sckPrev_r <= 1'b0;
            csPrev_r  <= 1'b1;
            phase_r   <= PH_OPCODE;
            bitCnt_r  <= '0;
            shift_r   <= '0;
            opc_r     <= '0;
            addr_r    <= '0;
            txByte_r  <= '0;
            so_r      <= 1'b0;
            oe_r      <= 1'b0;
            memRdReq  <= 1'b0;
            memRdAck_r <= 1'b0;
            soLive_r  <= 1'b0;
        end else if (clkEn) begin
            sckPrev_r <= sck;
            csPrev_r  <= csN;
            memRdReq  <= 1'b0;
            memRdAck_r <= memRdReq;
            if (csN) begin
                phase_r  <= PH_OPCODE;                   // R14 R04
                bitCnt_r <= '0;                          // R14
                oe_r     <= 1'b0;                        // R01
                soLive_r <= 1'b0;
            end else if (!holdN) begin
                oe_r <= 1'b0;                            // R11
            end else begin
                if (sckRise && phase_r != PH_IGNORE) begin
                    shift_r  <= rxByte;                  // R05
                    bitCnt_r <= (bitCnt_r == BIT_LAST) ? '0 : bitCnt_r + 1'b1;
                end
                if (byteDone) begin                      // R06
                    case (phase_r)
                        PH_OPCODE: begin
                            opc_r     <= opcBase;
                            addr_r[8] <= rxByte[3];      // a8 rides in bit 3
                            if (!opcValid) begin
                                phase_r <= PH_IGNORE;    // R16
                            end else if (opcBase == OPC_STAT_RD) begin
                                txByte_r <= statByte;
                                phase_r  <= PH_DATA;
                            end else if (opcBase == OPC_STAT_ST) begin
                                phase_r <= PH_DATA;
                            end else if (opcBase == OPC_MEM_RD ||
                                         opcBase == OPC_MEM_WR) begin
                                phase_r <= PH_ADDR;
                            end else begin
                                phase_r <= PH_IGNORE;
                            end
                        end
                        PH_ADDR: begin
                            addr_r[7:0] <= rxByte;
                            memRdReq    <= (opc_r == OPC_MEM_RD);
                            phase_r     <= PH_DATA;
                        end
                        PH_DATA: begin
                            addr_r <= addr_r + 9'h001;
                            if (opc_r == OPC_MEM_RD) memRdReq <= 1'b1;
                        end
                        default: phase_r <= PH_IGNORE;
                    endcase
                end
                if (phase_r == PH_DATA && opc_r == OPC_STAT_RD && bitCnt_r == '0)
                    txByte_r <= statByte;                // live status each byte
                // array answers one cycle after the request
                if (phase_r == PH_DATA && opc_r == OPC_MEM_RD && memRdAck_r)
                    txByte_r <= memRdData;
                if (sckFall && phase_r == PH_DATA && isRead) begin
                    so_r     <= txByte_r[3'(BIT_LAST - bitCnt_r)];  // R07
                    oe_r     <= 1'b1;
                    soLive_r <= 1'b1;
                end else begin
                    oe_r <= soLive_r;                    // R10 drive again after hold
                end
            end
        end
    end
    assign memRdAddr = addr_r;

    // =========================================================
    // write latch, status and program timer
    wire frameEndOk = csRise && bitCnt_r == '0;
    wire doSetWel   = frameEndOk && phase_r == PH_IGNORE && opc_r == OPC_SET_WEL;
    wire doClrWel   = frameEndOk && phase_r == PH_IGNORE && opc_r == OPC_CLR_WEL;
    wire startProg  = frameEndOk && phase_r == PH_DATA && isWrite && fifoOutValid && wrAllow;
    wire dropQueue  = csRise && fifoOutValid && !busy_r && !startProg;
    wire progDone   = busy_r && !fifoOutValid && progCnt_r == '0;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wel_r      <= 1'b0;
            bp_r       <= 2'b00;
            busy_r     <= 1'b0;
            discard_r  <= 1'b0;
            progCnt_r  <= '0;
            memWrValid <= 1'b0;
            memWrAddr  <= '0;
            memWrData  <= '0;
        end else if (clkEn) begin
            memWrValid <= 1'b0;
            if (!wpN || doClrWel || progDone) wel_r <= 1'b0;   // R08
            else if (doSetWel && !busy_r)     wel_r <= 1'b1;   // R17
            if (startProg) begin
                busy_r     <= 1'b1;                            // R18
                progCnt_r  <= ($bits(progCnt_r))'(PROG_CYCLES - 1);
            end else if (busy_r) begin                         // R02
                if (progCnt_r != '0) progCnt_r <= progCnt_r - 1'b1;  // R13
                if (progDone) busy_r <= 1'b0;                  // R18
            end
            // cut or refused frames leave bytes queued: pop them unwritten
            if (dropQueue)          discard_r <= 1'b1;   // R09
            else if (!fifoOutValid) discard_r <= 1'b0;
            if (drain && busy_r) begin
                if (fifoOut.isStatus) bp_r <= fifoOut.data[3:2];
                else begin
                    memWrValid <= 1'b1;
                    memWrAddr  <= fifoOut.addr;
                    memWrData  <= fifoOut.data;
                end
            end
        end
    end

    // only whole-byte frames with the latch set ever reach the array
    assign soOut            = so_r;
    assign soOe             = oe_r;
    assign blockProt        = bp_r;
    assign writeInProgress  = busy_r;
    assign writeEnableLatch = wel_r;
endmodule : spi_eeprom_pins
`default_nettype wire

// >>> src/eeprom_pkg.sv
/*
 * shared constants and types for the serial eeprom pin interface.
 * assumes a 250 MHz system clock that oversamples the serial pins.
 */
package eeprom_pkg;
    // =========================================================
    // timing
    localparam int CLK_MHZ                = 250;
    localparam int PROGRAM_CYCLE_TIME_US  = 4000;   // 4.0 ms
    localparam int PROGRAM_CYCLES         = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
    // =========================================================
    // opcodes (upper nibble zero, bit 3 ignored)
    localparam logic [7:0] OPC_MASK       = 8'hF7;
    localparam logic [7:0] OPC_SET_WEL    = 8'h06;
    localparam logic [7:0] OPC_CLR_WEL    = 8'h04;
    localparam logic [7:0] OPC_STAT_RD    = 8'h05;
    localparam logic [7:0] OPC_STAT_ST    = 8'h01;
    localparam logic [7:0] OPC_MEM_RD     = 8'h03;
    localparam logic [7:0] OPC_MEM_WR     = 8'h02;
    localparam logic [3:0] STAT_TOP_ONES  = 4'hF;
    localparam logic [3:0] BIT_LAST       = 4'h7;
    localparam logic [3:0] BIT_BYTE       = 4'h8;
    localparam int         FIFO_DEPTH     = 8;

    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_ADDR   = 2'b01,
        PH_DATA   = 2'b11,
        PH_IGNORE = 2'b10
    } phase_e;

    // write request handed to the program engine
    typedef struct packed {
        logic       isStatus;
        logic [8:0] addr;
        logic [7:0] data;
    } wr_req_s;
endpackage : eeprom_pkg

// >>> src/wr_fifo.sv
/*
 * small synchronous fifo holding page-write bytes.
 * assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module wr_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             clkEn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      rdPtr_r;
    wire  [AW:0]      fill = wrPtr_r - rdPtr_r;
    wire              push = inValid && inReady && clkEn;
    wire              pop  = outValid && outReady && clkEn;

    assign inReady  = (fill != (AW+1)'(DEPTH));
    assign outValid = (fill != '0);
    assign outData  = mem[rdPtr_r[AW-1:0]];

    always_ff @(posedge clock) begin
        if (push) mem[wrPtr_r[AW-1:0]] <= inData;
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (push) wrPtr_r <= wrPtr_r + 1'b1;
            if (pop)  rdPtr_r <= rdPtr_r + 1'b1;
        end
    end
endmodule : wr_fifo
`default_nettype wire

// >>> bench/spi_eeprom_pins_checker.sv
/* checker: pin-level relations of the eeprom pin block.
   assumes pins are slow against clock and synced in about 3 cycles. */
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_pins_checker #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic csPin_n,
    input wire logic sckPin,
    input wire logic wpPin_n,
    input wire logic holdPin_n,
    input wire logic soOut,
    input wire logic soOe,
    input wire logic memWrValid,
    input wire logic writeInProgress,
    input wire logic writeEnableLatch
);
    // ==========================================
    // helpers: cycles since sck fell, cycles busy
    logic        sck_r;
    logic [3:0]  sinceFall_r;
    logic [31:0] busy_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sck_r       <= 1'b0;
            sinceFall_r <= 4'hF;
            busy_r      <= 32'h0;
        end else begin
            sck_r       <= sckPin;
            sinceFall_r <= (sck_r && !sckPin) ? 4'h0 : sinceFall_r + {3'h0, sinceFall_r != 4'hF};
            busy_r      <= writeInProgress ? busy_r + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // sequences
    sequence deselected_s; csPin_n [*8]; endsequence
    sequence soMoved_s; soOe && $past(soOe) && $changed(soOut); endsequence
    // ==========================================
    // assertions
    AST_CS_TRISTATE: assert property (deselected_s |-> !soOe)
        else $error("so driven while deselected");
    AST_HOLD_TRISTATE: assert property ((!holdPin_n) [*8] |-> !soOe)
        else $error("so driven during hold");
    AST_WP_CLEARS: assert property ((!wpPin_n) [*6] |-> !writeEnableLatch)
        else $error("latch set while protected");
    AST_SO_ON_FALL: assert property (soMoved_s |-> sinceFall_r < 4'h8)
        else $error("so moved without sck fall");
    AST_WIP_BOUND: assert property (busy_r <= PROG_CYCLES + 8)
        else $error("program cycle too long");
    AST_WIP_START: assert property ($rose(writeInProgress) |-> csPin_n)
        else $error("program started inside frame");
    AST_WR_IN_WIP: assert property (memWrValid |-> writeInProgress)
        else $error("array write while not busy");
    AST_LATCH_SET: assert property ($rose(writeEnableLatch) |-> csPin_n && wpPin_n)
        else $error("latch set outside frame end");
endmodule : spi_eeprom_pins_checker
`default_nettype wire

// >>> bench/spi_host_model.sv
/* spi host model, mode 0, 32 ns serial clock.
   assumes so is high-z when the device does not drive it. */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic     csPin_n,
    output logic     sckPin,
    output logic     siPin,
    output logic     holdPin_n,
    input wire logic soLine
);
    logic [7:0] rxByte;
    initial begin
        csPin_n = 1'b1;
        sckPin = 1'b0;
        siPin = 1'b0;
        holdPin_n = 1'b1;
        rxByte = 8'h00;
    end
    // ==========================================
    // frame tasks; odd offset keeps sck out of phase
    task automatic begin_frame();
        #0.7 csPin_n = 1'b0;
        #20;
    endtask : begin_frame
    // sends tx[n-1:0] msb first, so read late in high phase
    task automatic shift(input int n, input logic [7:0] tx);
        for (int i = n - 1; i >= 0; i--) begin
            siPin = tx[i];
            #16 sckPin = 1'b1;
            #15 rxByte = {rxByte[6:0], soLine};
            #1 sckPin = 1'b0;
        end
    endtask : shift
    // cs stays low; sck and si wiggle to prove they are ignored
    // hold moves only while sck has been low a while, never with an sck edge
    task automatic hold_pause();
        #16 holdPin_n = 1'b0;
        repeat (3) begin
            siPin = ~siPin;
            #16 sckPin = 1'b1;
            #16 sckPin = 1'b0;
        end
        #16 holdPin_n = 1'b1;
        #16;
    endtask : hold_pause
    task automatic end_frame();
        #16 csPin_n = 1'b1;
        siPin = ~siPin;
        #200;
    endtask : end_frame
endmodule : spi_host_model
`default_nettype wire

// >>> bench/spi_eeprom_pin_interface_tb.sv
/* self-checking bench of the eeprom pin block with host model.
   assumes a short program time parameter and an array model here. */
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_pin_interface_tb;
    import eeprom_pkg::*;
    localparam int PROG = 200;
    logic       clock, rst_n, csPin_n, sckPin, siPin, wpPin_n, holdPin_n, soOut, soOe;
    logic       memWrValid, memRdReq, writeInProgress, writeEnableLatch;
    logic [8:0] memWrAddr, memRdAddr, a;
    logic [7:0] memWrData, memRdData, d0, d1;
    logic [1:0] blockProt;
    logic [7:0] mem [512];
    int         expMem [512];
    int         fails, num_checks, cycles, n, latchM, bpM;
    wire        soLine = soOe ? soOut : 1'bz;
    spi_eeprom_pins #(.PROG_CYCLES(PROG)) i_dut (.clock, .rst_n, .clkEn(1'b1), .csPin_n,
        .sckPin, .siPin, .wpPin_n, .holdPin_n, .soOut, .soOe, .memWrValid, .memWrAddr,
        .memWrData, .memRdReq, .memRdAddr, .memRdData, .blockProt, .writeInProgress,
        .writeEnableLatch);
    spi_host_model i_host (.csPin_n, .sckPin, .siPin, .holdPin_n, .soLine);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // array model answers one cycle after the request
    always @(posedge clock) begin
        if (memWrValid) mem[memWrAddr] <= memWrData;
        if (memRdReq) memRdData <= mem[memRdAddr];
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
    // ==========================================
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] op);
        i_host.begin_frame();
        i_host.shift(8, op);
        i_host.end_frame();
    endtask : cmd
    task automatic rdsr();
        i_host.begin_frame();
        i_host.shift(8, OPC_STAT_RD);
        i_host.shift(8, 8'($urandom));
        i_host.end_frame();
        check(i_host.rxByte, 8'(32'hF0 + bpM * 4 + latchM * 2));
    endtask : rdsr
    // write two bytes, or read two back; a8 rides in opcode bit 3
    task automatic mem_op(input logic [7:0] op, input logic isRead);
        i_host.begin_frame();
        i_host.shift(8, op | {4'h0, a[8], 3'h0});
        i_host.shift(8, a[7:0]);
        i_host.shift(8, d0);
        if (isRead) check(i_host.rxByte, 8'(expMem[a]));
        i_host.shift(8, d1);
        if (isRead) check(i_host.rxByte, 8'(expMem[a + 9'h1]));
        i_host.end_frame();
    endtask : mem_op
    task automatic wait_idle();
        check(8'(writeInProgress), 8'h01);
        n = 0;
        while (writeInProgress === 1'b1 && n < PROG + 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(8'(writeInProgress), 8'h00);
        latchM = 0;
    endtask : wait_idle
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // ==========================================
    // main sequence
    initial begin
        n = $urandom(32'hAC13);
        rst_n = 1'b0;
        wpPin_n = 1'b1;
        memRdData = 8'h00;
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'hFF;
            expMem[i] = 255;
        end
        repeat (5) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check(8'(soOe), 8'h00);
        rdsr();
        cmd(OPC_SET_WEL);
        latchM = 1;
        rdsr();
        cmd(OPC_CLR_WEL);
        latchM = 0;
        rdsr();
        i_host.begin_frame();
        i_host.shift(8, 8'hFF);
        i_host.shift(8, OPC_SET_WEL);
        i_host.end_frame();
        rdsr();
        a = 9'($urandom) & 9'h1FE;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        cmd(OPC_SET_WEL);
        @(posedge clock) #1 wpPin_n = 1'b0;
        repeat (10) @(posedge clock);
        check(8'(writeEnableLatch), 8'h00);
        mem_op(OPC_MEM_WR, 1'b0);
        check(8'(writeInProgress), 8'h00);
        @(posedge clock) #1 wpPin_n = 1'b1;
        mem_op(OPC_MEM_RD, 1'b1);
        cmd(OPC_SET_WEL);
        mem_op(OPC_MEM_WR, 1'b0);
        expMem[a] = d0;
        expMem[a + 9'h1] = d1;
        wait_idle();
        rdsr();
        mem_op(OPC_MEM_RD, 1'b1);
        cmd(OPC_SET_WEL);
        latchM = 1;
        i_host.begin_frame();
        i_host.shift(8, OPC_STAT_RD);
        i_host.shift(4, 8'($urandom));
        i_host.hold_pause();
        i_host.shift(4, 8'($urandom));
        i_host.end_frame();
        check(i_host.rxByte, 8'hF2);
        i_host.begin_frame();
        i_host.shift(8, OPC_STAT_ST);
        i_host.shift(8, 8'h0C);
        i_host.end_frame();
        wait_idle();
        bpM = 3;
        check(8'(blockProt), 8'h03);
        rdsr();
        test_done();
    end
endmodule : spi_eeprom_pin_interface_tb
bind spi_eeprom_pins spi_eeprom_pins_checker #(.PROG_CYCLES(PROG_CYCLES)) i_chk (.clock,
    .rst_n, .csPin_n, .sckPin, .wpPin_n, .holdPin_n, .soOut, .soOe, .memWrValid,
    .writeInProgress, .writeEnableLatch);
`default_nettype wire
